// File: rtl/irq_comb_if.sv
`timescale 1ns/100ps
// Classic Wishbone between driver end and combiner
interface irq_comb_if;
	import irq_comb_pkg::*;
	logic cyc;
	logic stb;
	logic we;
	logic [3:0] sel;
	logic [AW-1:0] adr;
	logic [DW-1:0] dat_w;
	logic [DW-1:0] dat_r;
	logic ack;
	modport dev (input cyc, stb, we, sel, adr, dat_w, output dat_r, ack);
	modport host (output cyc, stb, we, sel, adr, dat_w, input dat_r, ack);
endinterface

// File: rtl/irq_comb_pkg.sv
// Notes on behaviour
// - Tx pulse comes from eight channel pending bits
// - Mask-set write of 1 enables channel only
// - Only routed channels drive tx pulse; status readable
// - Completion pointer write raises channel pending
// - Host pointer write clears pending when equal
// - EOI codes 2,0,3 re-arm tx, thresh, misc
// - EOI code 1 re-arms receive completion pulse
// - Mask-clear write of 1 disables channel only
// - Routing all off silences pulse; status still readable
// - Threshold pulse immediate from eight channel bits
// - Threshold routing enable gates both the pulse and the masked status read
// - Threshold pends when free count <= threshold
// - Rx mask clear or routing clear stops pulse
// - Misc pulse from four sources, routed and readable
// - Stats and host error enabled by mask set
// - Stats pends while any counter >= 0x80000000
// - Host error sticky until reset; raw/masked readable
// - Six transmit descriptor error conditions
// - Four receive descriptor error conditions
// - Host error mask clear stops propagation
// - Link change on monitored PHY, if enabled, captured
// - User access start bit falling, if masked in, captured
package irq_comb_pkg;
	// Channel and word widths
	localparam int NCH = 8;
	localparam int AW = 8;
	localparam int DW = 32;
	// Register offsets (byte addresses)
	localparam logic [AW-1:0] A_TX_RAW = 8'h00;
	localparam logic [AW-1:0] A_TX_MSK = 8'h04;
	localparam logic [AW-1:0] A_TX_SET = 8'h08;
	localparam logic [AW-1:0] A_TX_CLR = 8'h0C;
	localparam logic [AW-1:0] A_TX_EN = 8'h10;
	localparam logic [AW-1:0] A_TX_STAT = 8'h14;
	localparam logic [AW-1:0] A_RX_SET = 8'h18;
	localparam logic [AW-1:0] A_RX_CLR = 8'h1C;
	localparam logic [AW-1:0] A_TH_EN = 8'h20;
	localparam logic [AW-1:0] A_TH_STAT = 8'h24;
	localparam logic [AW-1:0] A_DMA_SET = 8'h28;
	localparam logic [AW-1:0] A_DMA_CLR = 8'h2C;
	localparam logic [AW-1:0] A_DMA_RAW = 8'h30;
	localparam logic [AW-1:0] A_DMA_MSK = 8'h34;
	localparam logic [AW-1:0] A_MISC_EN = 8'h38;
	localparam logic [AW-1:0] A_MISC_STAT = 8'h3C;
	localparam logic [AW-1:0] A_EOI = 8'h40;
	localparam logic [AW-1:0] A_RX_STAT = 8'h44;
	localparam logic [AW-1:0] A_RX_EN = 8'h48;
	localparam logic [AW-1:0] A_LINK_CAP = 8'h4C;
	localparam logic [AW-1:0] A_USER_CAP = 8'h50;
	localparam logic [AW-1:0] A_LINK_EN = 8'h54;
	localparam logic [AW-1:0] A_USER_EN = 8'h58;
	// Per-channel pointer base: 0x80 + 4*ch (tx), 0xC0 + 4*ch (rx)
	localparam logic [AW-1:0] A_TX_CP = 8'h80;
	localparam logic [AW-1:0] A_RX_CP = 8'hC0;
	localparam logic [AW-1:0] A_CP_MASK = 8'hE0;
	// DMA mask bit positions
	localparam int B_STAT = 0;
	localparam int B_HOST = 1;
	// Misc source bit positions
	localparam int M_STAT = 0;
	localparam int M_HOST = 1;
	localparam int M_LINK = 2;
	localparam int M_USER = 3;
	// End-of-interrupt codes
	localparam logic [1:0] EOI_TH = 2'h0;
	localparam logic [1:0] EOI_RX = 2'h1;
	localparam logic [1:0] EOI_TX = 2'h2;
	localparam logic [1:0] EOI_MISC = 2'h3;
	// Statistics overflow threshold
	localparam logic [DW-1:0] STAT_HALF = 32'h80000000;
	// Reset value of registers
	localparam logic [DW-1:0] ZERO = 32'h00000000;
endpackage

// File: rtl/irq_combiner.sv
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module irq_combiner
	import irq_comb_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// Software side
	irq_comb_if.dev bus,
	// DMA completion write-back strobes
	input wire logic tx_done_stb,
	input wire logic rx_done_stb,
	input wire logic [2:0] done_ch,
	input wire logic [DW-1:0] done_addr,
	// Receive buffer accounting
	input wire logic [NCH*16-1:0] rx_free_buffer_count,
	input wire logic [NCH*16-1:0] rx_pending_threshold,
	// Statistics counters
	input wire logic stat_any_high,
	// Descriptor checks, one-cycle strobe with decoded fields
	input wire logic desc_chk_stb,
	input wire logic desc_is_rx,
	input wire logic first_buffer_flag,
	input wire logic last_buffer_flag,
	input wire logic sop_err,
	input wire logic own_flag,
	input wire logic [DW-1:0] next_ptr,
	input wire logic [DW-1:0] buf_ptr,
	input wire logic [15:0] buf_len,
	input wire logic [15:0] buf_off,
	input wire logic pkt_len_err,
	// PHY management events
	input wire logic link_change,
	input wire logic [4:0] link_phy,
	input wire logic [4:0] monitored_phy_address,
	input wire logic access_start,
	// Pulse outputs
	output logic tx_irq_pulse,
	output logic rx_irq_pulse,
	output logic rx_low_buffer_irq_pulse,
	output logic misc_irq_pulse
);
	////////////////////////////////////////////////////////////////
	// Declarations
	logic [NCH-1:0] tx_mask; // Channel mask
	logic [NCH-1:0] rx_mask; // Receive mask
	logic [NCH-1:0] tx_en; // Routing enables
	logic [NCH-1:0] rx_en;
	logic [NCH-1:0] th_en;
	logic [3:0] misc_en;
	logic [1:0] dma_mask; // Stats and host error masks
	logic [NCH-1:0] tx_channel_pending; // Raw pending
	logic [NCH-1:0] rx_pend;
	logic [NCH-1:0] rx_low_buffer_pending;
	logic [DW-1:0] tx_cp [NCH]; // Completion pointers
	logic [DW-1:0] rx_cp [NCH];
	logic descriptor_error_pending;
	logic link_en;
	logic user_en;
	logic link_irq_masked_capture;
	logic user_access_masked_capture;
	logic start_q; // Start bit history
	logic [3:0] armed; // Pulse armed per output
	logic [NCH-1:0] tx_irq_masked_status;
	logic [NCH-1:0] tx_stat;
	logic [NCH-1:0] rx_stat;
	logic [NCH-1:0] rx_low_buffer_masked_status;
	logic [3:0] dma_misc_raw_status;
	logic [3:0] misc_stat;
	logic [3:0] any;
	logic wr;
	logic rd;
	logic [2:0] cp_ch;
	logic desc_err;

	// Bit set or clear for writes of 1 only
	function automatic logic [NCH-1:0] upd(input logic [NCH-1:0] cur, input logic [NCH-1:0] d, input logic set);
		upd = set ? (cur | d) : (cur & ~d);
	endfunction

	////////////////////////////////////////////////////////////////
	// Bus decode
	// Write lands at the edge where the master samples ack high
	assign wr = bus.cyc && bus.stb && bus.we && bus.ack && ce;
	assign rd = bus.cyc && bus.stb && !bus.we && !bus.ack && ce;
	assign cp_ch = bus.adr[4:2];

	// Acknowledge one cycle after request
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bus.ack <= 1'b0;
		end else if (ce) begin
			bus.ack <= bus.cyc && bus.stb && !bus.ack;
		end
	end

	////////////////////////////////////////////////////////////////
	// Mask and routing registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_mask <= '0;
			rx_mask <= '0;
			tx_en <= '0;
			rx_en <= '0;
			th_en <= '0;
			misc_en <= '0;
			dma_mask <= '0;
			link_en <= 1'b0;
			user_en <= 1'b0;
		end else if (wr) begin
			case (bus.adr)
				A_TX_SET: tx_mask <= upd(tx_mask, bus.dat_w[NCH-1:0], 1'b1);
				A_TX_CLR: tx_mask <= upd(tx_mask, bus.dat_w[NCH-1:0], 1'b0);
				A_RX_SET: rx_mask <= upd(rx_mask, bus.dat_w[NCH-1:0], 1'b1);
				A_RX_CLR: rx_mask <= upd(rx_mask, bus.dat_w[NCH-1:0], 1'b0);
				A_TX_EN: tx_en <= bus.dat_w[NCH-1:0];
				A_RX_EN: rx_en <= bus.dat_w[NCH-1:0];
				A_TH_EN: th_en <= bus.dat_w[NCH-1:0];
				A_MISC_EN: misc_en <= bus.dat_w[3:0];
				A_DMA_SET: dma_mask <= dma_mask | bus.dat_w[1:0];
				A_DMA_CLR: dma_mask <= dma_mask & ~bus.dat_w[1:0];
				A_LINK_EN: link_en <= bus.dat_w[0];
				A_USER_EN: user_en <= bus.dat_w[0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Completion pointers and pending; device write wins over host
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_channel_pending <= '0;
			rx_pend <= '0;
			for (int i = 0; i < NCH; i++) begin
				tx_cp[i] <= ZERO;
				rx_cp[i] <= ZERO;
			end
		end else if (ce) begin
			if (wr && (bus.adr & A_CP_MASK) == A_TX_CP && bus.dat_w == tx_cp[cp_ch]) begin
				tx_channel_pending[cp_ch] <= 1'b0;
			end
			if (wr && (bus.adr & A_CP_MASK) == A_RX_CP && bus.dat_w == rx_cp[cp_ch]) begin
				rx_pend[cp_ch] <= 1'b0;
			end
			if (tx_done_stb) begin
				tx_cp[done_ch] <= done_addr;
				tx_channel_pending[done_ch] <= 1'b1;
			end
			if (rx_done_stb) begin
				rx_cp[done_ch] <= done_addr;
				rx_pend[done_ch] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Threshold compare per channel
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			rx_low_buffer_pending[i] = rx_free_buffer_count[i*16 +: 16] <= rx_pending_threshold[i*16 +: 16];
		end
	end

	////////////////////////////////////////////////////////////////
	// Descriptor errors: sticky until reset
	assign desc_err = desc_is_rx ?
		(!own_flag || buf_ptr == ZERO || (!first_buffer_flag && buf_len == '0) ||
		(first_buffer_flag && buf_len <= buf_off)) :
		(sop_err || (first_buffer_flag && !own_flag) || (!last_buffer_flag && next_ptr == ZERO) ||
		buf_ptr == ZERO || buf_len == '0 || pkt_len_err);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			descriptor_error_pending <= 1'b0;
		end else if (ce && desc_chk_stb && desc_err) begin
			descriptor_error_pending <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// PHY management captures; clear on write 1, set wins
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			start_q <= 1'b0;
			link_irq_masked_capture <= 1'b0;
			user_access_masked_capture <= 1'b0;
		end else if (ce) begin
			start_q <= access_start;
			if (wr && bus.adr == A_LINK_CAP && bus.dat_w[0]) begin
				link_irq_masked_capture <= 1'b0;
			end
			if (wr && bus.adr == A_USER_CAP && bus.dat_w[0]) begin
				user_access_masked_capture <= 1'b0;
			end
			if (link_change && link_phy == monitored_phy_address && link_en) begin
				link_irq_masked_capture <= 1'b1;
			end
			if (start_q && !access_start && user_en) begin
				user_access_masked_capture <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Status and routing
	assign tx_irq_masked_status = tx_channel_pending & tx_mask;
	assign tx_stat = tx_irq_masked_status & tx_en;
	assign rx_stat = rx_pend & rx_mask & rx_en;
	assign rx_low_buffer_masked_status = rx_low_buffer_pending & rx_mask & th_en;
	assign dma_misc_raw_status = {user_access_masked_capture, link_irq_masked_capture,
		descriptor_error_pending, stat_any_high};
	assign misc_stat = dma_misc_raw_status & {2'b11, dma_mask} & misc_en;
	// Indexed by end-of-interrupt code: 0 thresh, 1 rx, 2 tx, 3 misc
	assign any = {|misc_stat, |tx_stat, |rx_stat, |rx_low_buffer_masked_status};

	////////////////////////////////////////////////////////////////
	// Pulse generation: one pulse, re-armed by EOI
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			armed <= 4'hF;
			tx_irq_pulse <= 1'b0;
			rx_irq_pulse <= 1'b0;
			rx_low_buffer_irq_pulse <= 1'b0;
			misc_irq_pulse <= 1'b0;
		end else if (ce) begin
			rx_irq_pulse <= armed[EOI_RX] && any[EOI_RX];
			tx_irq_pulse <= armed[EOI_TX] && any[EOI_TX];
			rx_low_buffer_irq_pulse <= armed[EOI_TH] && any[EOI_TH];
			misc_irq_pulse <= armed[EOI_MISC] && any[EOI_MISC];
			for (int i = 0; i < 4; i++) begin
				if (armed[i] && any[i]) begin
					armed[i] <= 1'b0;
				end
			end
			if (wr && bus.adr == A_EOI) begin
				armed[bus.dat_w[1:0]] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bus.dat_r <= ZERO;
		end else if (rd) begin
			bus.dat_r <= ZERO;
			case (bus.adr)
				A_TX_RAW: bus.dat_r[NCH-1:0] <= tx_channel_pending;
				A_TX_MSK: bus.dat_r[NCH-1:0] <= tx_irq_masked_status;
				A_TX_SET, A_TX_CLR: bus.dat_r[NCH-1:0] <= tx_mask;
				A_RX_SET, A_RX_CLR: bus.dat_r[NCH-1:0] <= rx_mask;
				A_TX_EN: bus.dat_r[NCH-1:0] <= tx_en;
				A_RX_EN: bus.dat_r[NCH-1:0] <= rx_en;
				A_TX_STAT: bus.dat_r[NCH-1:0] <= tx_stat;
				A_RX_STAT: bus.dat_r[NCH-1:0] <= rx_stat;
				A_TH_EN: bus.dat_r[NCH-1:0] <= th_en;
				A_TH_STAT: bus.dat_r[NCH-1:0] <= rx_low_buffer_masked_status;
				A_DMA_SET, A_DMA_CLR: bus.dat_r[1:0] <= dma_mask;
				A_DMA_RAW: bus.dat_r[3:0] <= dma_misc_raw_status;
				A_DMA_MSK: bus.dat_r[3:0] <= dma_misc_raw_status & {2'b11, dma_mask};
				A_MISC_EN: bus.dat_r[3:0] <= misc_en;
				A_MISC_STAT: bus.dat_r[3:0] <= misc_stat;
				A_LINK_CAP: bus.dat_r[0] <= link_irq_masked_capture;
				A_USER_CAP: bus.dat_r[0] <= user_access_masked_capture;
				A_LINK_EN: bus.dat_r[0] <= link_en;
				A_USER_EN: bus.dat_r[0] <= user_en;
				default: begin
					if ((bus.adr & A_CP_MASK) == A_TX_CP) begin
						bus.dat_r <= tx_cp[cp_ch];
					end else if ((bus.adr & A_CP_MASK) == A_RX_CP) begin
						bus.dat_r <= rx_cp[cp_ch];
					end
				end
			endcase
		end
	end
endmodule

// File: rtl/irq_driver.sv
`timescale 1ns/100ps
module irq_driver
	import irq_comb_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// Wishbone master side
	irq_comb_if.host bus,
	// User command port
	input wire logic cmd_valid,
	input wire logic cmd_we,
	input wire logic [AW-1:0] cmd_adr,
	input wire logic [DW-1:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [DW-1:0] rsp_rdata
);
	////////////////////////////////////////////////////////////////
	// Driver states
	typedef enum logic [1:0] {IDLE, BUSY, GAP} drv_e;
	drv_e state;

	// Ready only when idle
	assign cmd_ready = (state == IDLE);

	////////////////////////////////////////////////////////////////
	// Single classic cycle per command
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= IDLE;
			bus.cyc <= 1'b0;
			bus.stb <= 1'b0;
			bus.we <= 1'b0;
			bus.sel <= 4'h0;
			bus.adr <= '0;
			bus.dat_w <= ZERO;
			rsp_valid <= 1'b0;
			rsp_rdata <= ZERO;
		end else if (ce) begin
			rsp_valid <= 1'b0;
			case (state)
				IDLE: begin
					if (cmd_valid) begin
						// Mask writes use ones for effect; EOI writes carry the code
						bus.cyc <= 1'b1;
						bus.stb <= 1'b1;
						bus.we <= cmd_we;
						bus.sel <= 4'hF;
						bus.adr <= cmd_adr;
						bus.dat_w <= cmd_wdata;
						state <= BUSY;
					end
				end
				BUSY: begin
					if (bus.ack) begin
						bus.cyc <= 1'b0;
						bus.stb <= 1'b0;
						rsp_valid <= 1'b1;
						rsp_rdata <= bus.dat_r;
						state <= GAP;
					end
				end
				GAP: state <= IDLE;
				default: state <= IDLE;
			endcase
		end
	end
endmodule

// File: sim/irq_comb_checker.sv
`timescale 1ns/100ps
// Watches the bus between driver end and combiner
module irq_comb_checker
	import irq_comb_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bus signals
	input wire logic cyc,
	input wire logic stb,
	input wire logic we,
	input wire logic [3:0] sel,
	input wire logic [AW-1:0] adr,
	input wire logic [DW-1:0] dat_w,
	input wire logic [DW-1:0] dat_r,
	input wire logic ack
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Request waiting for its answer
	wire logic req = cyc && stb && !ack;
	////////////////////////////////////////////////////////////
	a_ack_next: assert property (req |=> ack)
		else $error("ack missing after request");
	a_ack_single: assert property (ack |=> !ack)
		else $error("ack held too long");
	a_ack_cause: assert property (ack |-> $past(req))
		else $error("ack without request");
	a_req_held: assert property (req |=> cyc && stb && $stable(adr) && $stable(we) && $stable(dat_w))
		else $error("request changed before ack");
	a_bus_release: assert property (ack |=> !cyc && !stb)
		else $error("bus not released after ack");
	a_cyc_stb: assert property (cyc == stb)
		else $error("cyc and stb differ");
	a_hole_zero: assert property (ack && !we && adr >= 8'h5C && adr < 8'h80 |-> dat_r == ZERO)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property ($changed(dat_r) |-> ack && !we)
		else $error("read data moved outside a read");
endmodule

// File: sim/test_ethernet_dma_interrupt_combiner.sv
`timescale 1ns/100ps
// Driver end and combiner joined by the bus
module test_ethernet_dma_interrupt_combiner;
	import irq_comb_pkg::*;
	// Stimulus
	logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, cmd_valid = 1'b0, cmd_we = 1'b0;
	logic tx_done_stb = 1'b0, rx_done_stb = 1'b0, stat_any_high = 1'b0, desc_chk_stb = 1'b0;
	logic desc_is_rx = 1'b0, first_buffer_flag = 1'b0, last_buffer_flag = 1'b0, sop_err = 1'b0;
	logic own_flag = 1'b1, pkt_len_err = 1'b0, link_change = 1'b0, access_start = 1'b0;
	logic [AW-1:0] cmd_adr = 8'h00;
	logic [2:0] done_ch = 3'h0;
	logic [DW-1:0] cmd_wdata = ZERO, done_addr = ZERO, next_ptr = ZERO, buf_ptr = ZERO;
	logic [15:0] buf_len = 16'h0000, buf_off = 16'h0000;
	logic [4:0] link_phy = 5'h00, monitored_phy_address = 5'h05;
	logic [NCH*16-1:0] rx_free_buffer_count = {NCH{16'hFFFF}}, rx_pending_threshold = '0;
	// Design outputs
	logic cmd_ready, rsp_valid, tx_irq_pulse, rx_irq_pulse, rx_low_buffer_irq_pulse, misc_irq_pulse;
	logic [DW-1:0] rsp_rdata, q, m, c, th;
	logic [DW-1:0] ad [NCH];
	// Counters and model state
	int failures = 0, compares = 0, cyc_n = 0, f, t;
	int n_tx = 0, n_rx = 0, n_th = 0, n_mi = 0, e_tx = 0, e_rx = 0, e_th = 0, e_mi = 0;
	irq_comb_if bus_if();
	irq_combiner irq_combiner_inst(.mclk, .rst_b, .ce, .bus(bus_if), .tx_done_stb, .rx_done_stb,
		.done_ch, .done_addr, .rx_free_buffer_count, .rx_pending_threshold, .stat_any_high,
		.desc_chk_stb, .desc_is_rx, .first_buffer_flag, .last_buffer_flag, .sop_err, .own_flag,
		.next_ptr, .buf_ptr, .buf_len, .buf_off, .pkt_len_err, .link_change, .link_phy,
		.monitored_phy_address, .access_start, .tx_irq_pulse, .rx_irq_pulse,
		.rx_low_buffer_irq_pulse, .misc_irq_pulse);
	irq_driver irq_driver_inst(.mclk, .rst_b, .ce, .bus(bus_if), .cmd_valid, .cmd_we, .cmd_adr,
		.cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata);
	irq_comb_checker irq_comb_checker_inst(.mclk, .rst_b, .cyc(bus_if.cyc), .stb(bus_if.stb),
		.we(bus_if.we), .sel(bus_if.sel), .adr(bus_if.adr), .dat_w(bus_if.dat_w),
		.dat_r(bus_if.dat_r), .ack(bus_if.ack));
	////////////////////////////////////////////////////////////
	// Clock
	initial forever #12.5 mclk = ~mclk;
	// Pulse counters and hang guard
	always @(posedge mclk) begin
		n_tx += int'(tx_irq_pulse === 1'b1);
		n_rx += int'(rx_irq_pulse === 1'b1);
		n_th += int'(rx_low_buffer_irq_pulse === 1'b1);
		n_mi += int'(misc_irq_pulse === 1'b1);
		cyc_n++;
		if (cyc_n == 8000) begin
			failures++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic test_done();
		if (failures == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One comparison
	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus cycle through the driver's command port
	task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_we <= w;
		cmd_adr <= a;
		cmd_wdata <= d;
		@(negedge mclk);
		chk(cmd_ready, 1'b1);
		@(posedge mclk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge mclk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 50);
		if (n == 50) failures++;
		q = rsp_rdata;
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
		bus(1'b0, a, ZERO);
		chk(q, e);
	endtask
	// Pulse tallies against the model
	task automatic pc();
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk(n_tx, e_tx);
		chk(n_rx, e_rx);
		chk(n_th, e_th);
		chk(n_mi, e_mi);
	endtask
	// Completion write-back strobe
	task automatic done(input logic r, input logic [2:0] ch, input logic [DW-1:0] a);
		@(posedge mclk);
		tx_done_stb <= !r;
		rx_done_stb <= r;
		done_ch <= ch;
		done_addr <= a;
		@(posedge mclk);
		tx_done_stb <= 1'b0;
		rx_done_stb <= 1'b0;
	endtask
	// Descriptor check strobe
	task automatic desc(input logic r, input logic fb, input logic [15:0] l, input logic [15:0] o);
		@(posedge mclk);
		desc_chk_stb <= 1'b1;
		desc_is_rx <= r;
		first_buffer_flag <= fb;
		last_buffer_flag <= !r;
		next_ptr <= $urandom;
		buf_ptr <= $urandom | 32'h00000001;
		buf_len <= l;
		buf_off <= o;
		@(posedge mclk);
		desc_chk_stb <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(59522));
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		// Reset values and the unmapped hole
		for (int i = 0; i <= 22; i++) rd(AW'(4 * i), ZERO);
		wr(8'h5C, 32'hFFFFFFFF);
		rd(8'h5C, ZERO);
		// Transmit completion
		m = $urandom_range(255) | 32'h00000001;
		c = $urandom_range(255) & 32'h000000FE;
		wr(A_TX_SET, m);
		wr(A_TX_CLR, c);
		m = m & ~c;
		for (int i = 0; i < NCH; i++) begin
			ad[i] = $urandom;
			done(1'b0, i[2:0], ad[i]);
		end
		pc();
		rd(A_TX_RAW, 32'h000000FF);
		rd(A_TX_CP, ad[0]);
		rd(A_TX_MSK, m);
		rd(A_TX_STAT, ZERO);
		wr(A_TX_EN, 32'h000000FF);
		e_tx = 1;
		pc();
		rd(A_TX_STAT, m);
		for (int i = 0; i < NCH; i++) wr(A_TX_CP + AW'(4 * i), ad[i] ^ DW'(i % 2));
		m = m & 32'h000000AA;
		rd(A_TX_MSK, m);
		wr(A_EOI, 32'(EOI_TX));
		e_tx += int'(m != ZERO);
		pc();
		// Receive completion
		wr(A_RX_SET, 32'h000000FF);
		wr(A_RX_CLR, 32'h00000030);
		wr(A_RX_EN, 32'h000000FF);
		done(1'b1, 3'h3, 32'h00001234);
		e_rx = 1;
		pc();
		rd(A_RX_STAT, 32'h00000008);
		wr(A_EOI, 32'(EOI_RX));
		e_rx = 2;
		pc();
		wr(A_RX_CP + 8'h0C, 32'h00001234);
		rd(A_RX_STAT, ZERO);
		// Low free-buffer threshold
		th = ZERO;
		@(posedge mclk);
		for (int i = 0; i < NCH; i++) begin
			f = i ? $urandom_range(15) : 0;
			t = $urandom_range(15);
			rx_free_buffer_count[16*i +: 16] <= 16'(f);
			rx_pending_threshold[16*i +: 16] <= 16'(t);
			th[i] = (f <= t);
		end
		wr(A_TH_EN, 32'h000000FF);
		e_th = 1;
		pc();
		rd(A_TH_STAT, th & 32'h000000CF);
		wr(A_EOI, 32'(EOI_TH));
		e_th = 2;
		pc();
		wr(A_TH_EN, ZERO);
		wr(A_EOI, 32'(EOI_TH));
		pc();
		rd(A_TH_STAT, ZERO);
		// Miscellaneous sources
		wr(A_DMA_SET, 32'h00000003);
		wr(A_MISC_EN, 32'h0000000F);
		wr(A_LINK_EN, 32'hFFFFFFFF);
		wr(A_USER_EN, 32'hFFFFFFFF);
		@(posedge mclk);
		stat_any_high <= 1'b1;
		e_mi = 1;
		pc();
		desc(1'b0, 1'b1, 16'h0040, 16'h0000);
		desc(1'b1, 1'b0, 16'h0008, 16'h0020);
		rd(A_DMA_RAW, 32'h00000001);
		desc(1'b1, 1'b1, 16'h0010, 16'h0010);
		rd(A_DMA_MSK, 32'h00000003);
		wr(A_EOI, 32'(EOI_MISC));
		e_mi = 2;
		pc();
		@(posedge mclk);
		stat_any_high <= 1'b0;
		wr(A_DMA_CLR, 32'h00000002);
		rd(A_DMA_RAW, 32'h00000002);
		rd(A_DMA_MSK, ZERO);
		wr(A_EOI, 32'(EOI_MISC));
		pc();
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk);
			link_change <= 1'b1;
			link_phy <= i ? monitored_phy_address : 5'h06;
			@(posedge mclk);
			link_change <= 1'b0;
			e_mi = 2 + i;
			pc();
		end
		@(posedge mclk);
		access_start <= 1'b1;
		@(posedge mclk);
		access_start <= 1'b0;
		pc();
		rd(A_MISC_STAT, 32'h0000000C);
		wr(A_EOI, 32'(EOI_MISC));
		e_mi = 4;
		pc();
		wr(A_LINK_CAP, 32'hFFFFFFFF);
		wr(A_USER_CAP, 32'hFFFFFFFF);
		wr(A_EOI, 32'(EOI_MISC));
		pc();
		rd(A_MISC_STAT, ZERO);
		// Second reset clears the sticky error, then a transmit error
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		rd(A_DMA_RAW, ZERO);
		desc(1'b0, 1'b1, 16'h0000, 16'h0000);
		rd(A_DMA_RAW, 32'h00000002);
		test_done();
	end
endmodule
